// *** pll_config_pkg.sv ***
// Package with the offsets, reset image, field positions and carriers of the PLL configuration bank.
// What this block does
// - Crystal_load_trim holds a read/write eight-bit crystal load trim whose binary-weighted bits set the load.
// - Pll3_reference_divider bits 7 and 6 enable the third PLL's divide-by-1 bypass and divide-by-2 reference paths.
// - Pll3_reference_divider bits 5:0 hold the third PLL reference divider, legal 3 to 64, reset 25.
// - The third PLL feedback divider takes bits 7:0 from pll3_feedback_divider_low and 10:8 from pll3_filter_and_feedback_high, reset 480.
// - Pll3_filter_and_feedback_high bits 7:4 add 100k, 50k, 25k, 12.5k ohm to the third PLL filter; bit 3 alone means 6k.
// - Pll3_charge_pump_and_source bit 7 picks output divider 3's source, second PLL when clear, third PLL when set.
// - Pll3_charge_pump_and_source bits 6:1 set the third PLL pump multipliers x8..x1 and divisors /24 and /3.
// - Pll3_charge_pump_and_source bit 0 selects the third PLL reference current, 10 uA clear or 20 uA set.
// - Pll1_control_and_divider5 holds the first PLL doubler, reference current, channel 2 enable and third pole enable.
// - Pll1_control_and_divider5 bits 3:0 hold the output divider 5 code, reset to binary 0011.
// - Pll1_reference_divider holds the first PLL bypass path enables and its reference divider, reset 25.
// - The first PLL feedback divider takes bits 7:0 from pll1_feedback_divider_low and 10:8 from pll1_filter_and_feedback_high, reset 600.
// - Pll1_filter_and_feedback_high bits 7:4 add first PLL filter resistors, bit 3 alone means 1k, reset 100k+25k+12.5k.
// - Pll1_charge_pump sets first PLL pump multipliers x32..x1 and divisors /24 and /3, reset x1 and /24.
// - Bytes of a block write are held until STOP and then all written into the bank at once.
package pll_config_pkg;

   // ==========================================================
   // Address map.
   localparam logic [7:0] ADDR_CRYSTAL_LOAD_TRIM = 8'h02;
   localparam logic [7:0] ADDR_PLL3_REF_DIV = 8'h03;
   localparam logic [7:0] ADDR_PLL3_FB_LOW = 8'h04;
   localparam logic [7:0] ADDR_PLL3_FILTER_FB_HIGH = 8'h05;
   localparam logic [7:0] ADDR_PLL3_PUMP_SOURCE = 8'h06;
   localparam logic [7:0] ADDR_PLL1_CTRL_DIV5 = 8'h07;
   localparam logic [7:0] ADDR_PLL1_REF_DIV = 8'h08;
   localparam logic [7:0] ADDR_PLL1_FB_LOW = 8'h09;
   localparam logic [7:0] ADDR_PLL1_FILTER_FB_HIGH = 8'h0a;
   localparam logic [7:0] ADDR_PLL1_PUMP = 8'h0b;
   localparam int NUM_REGS = 10;
   localparam int IDX_W = 4;

   // ==========================================================
   // Power-up values, pll1_charge_pump in the top lane down to crystal_load_trim in the low lane.
   localparam logic [NUM_REGS*8-1:0] RESET_IMAGE = {
      8'h06, 8'hb2, 8'h58, 8'h19, 8'h23, 8'h6c, 8'h11, 8'he0, 8'h19, 8'h11};

   // ==========================================================
   // Field positions; the reference, feedback and filter ones are shared by the third and first PLL bytes.
   localparam int POS_BYPASS_DIV1 = 7;
   localparam int POS_PATH_DIV2 = 6;
   localparam int POS_REF_DIV_MSB = 5;
   localparam int POS_FB_HIGH_MSB = 2;
   localparam int POS_FILTER_MSB = 7;
   localparam int POS_FILTER_LSB = 4;
   localparam int POS_FILTER_LOW_ONLY = 3;
   localparam int POS_DIV3_SOURCE = 7;
   localparam int POS_PLL3_MULT_MSB = 6;
   localparam int POS_PLL3_MULT_LSB = 3;
   localparam int POS_PLL3_DIV24 = 2;
   localparam int POS_PLL3_DIV3 = 1;
   localparam int POS_PLL3_IREF = 0;
   localparam int POS_DOUBLER = 7;
   localparam int POS_PLL1_IREF = 6;
   localparam int POS_CH2_EN = 5;
   localparam int POS_THIRD_POLE = 4;
   localparam int POS_DIV5_MSB = 3;
   localparam int POS_PLL1_MULT_MSB = 7;
   localparam int POS_PLL1_MULT_LSB = 2;
   localparam int POS_PLL1_DIV24 = 1;
   localparam int POS_PLL1_DIV3 = 0;

   // ==========================================================
   // Carriers.
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } byte_write_t;

   typedef struct packed {
      logic third_pll_ref_bypass_div1;
      logic third_pll_ref_path_div2;
      logic [5:0] third_pll_ref_divider;
      logic [10:0] third_pll_feedback_divider;
      logic [3:0] third_pll_filter_res;
      logic third_pll_filter_res_6k_only;
      logic [3:0] third_pll_pump_mult;
      logic third_pll_pump_div24;
      logic third_pll_pump_div3;
      logic third_pll_ref_current_sel;
   } third_pll_cfg_t;

   typedef struct packed {
      logic first_pll_ref_doubler;
      logic first_pll_ref_current_sel;
      logic first_pll_channel2_enable;
      logic first_pll_third_pole_enable;
      logic first_pll_ref_bypass_div1;
      logic first_pll_ref_path_div2;
      logic [5:0] first_pll_ref_divider;
      logic [10:0] first_pll_feedback_divider;
      logic [3:0] first_pll_filter_res;
      logic first_pll_filter_res_1k_only;
      logic [5:0] first_pll_pump_mult;
      logic first_pll_pump_div24;
      logic first_pll_pump_div3;
   } first_pll_cfg_t;

   typedef struct packed {
      logic [7:0] crystal_load_trim;
      logic divider3_source_select;
      logic [3:0] divider5_code;
   } misc_cfg_t;

endpackage : pll_config_pkg

// *** pll_config_register_bank.sv ***
// Configuration register bank for bytes 02h to 0Bh with block-write staging.
module pll_config_register_bank
   import pll_config_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic wr_valid_i,
   input wire byte_write_t wr_req_i,
   input wire logic stop_i,
   input wire logic rd_valid_i,
   input wire logic [7:0] rd_addr_i,
   output logic [7:0] rd_data_o,
   output logic rd_ack_o,
   output logic stage_pending_o,
   output third_pll_cfg_t third_pll_cfg_o,
   output first_pll_cfg_t first_pll_cfg_o,
   output misc_cfg_t misc_cfg_o,
   output logic [6:0] third_pll_pump_num_o,
   output logic [4:0] third_pll_pump_den_o,
   output logic [6:0] first_pll_pump_num_o,
   output logic [4:0] first_pll_pump_den_o
);

   // ==========================================================
   // Helper functions.

   // True when the byte address falls inside this bank.
   function automatic logic addr_in_bank(input logic [7:0] addr);
      addr_in_bank = (addr >= ADDR_CRYSTAL_LOAD_TRIM) && (addr <= ADDR_PLL1_PUMP);
   endfunction : addr_in_bank

   // Storage index of an in-bank byte address.
   function automatic logic [IDX_W-1:0] addr_index(input logic [7:0] addr);
      logic [7:0] diff;
      diff = addr - ADDR_CRYSTAL_LOAD_TRIM;
      addr_index = diff[IDX_W-1:0];
   endfunction : addr_index

   // Binary-weighted sum of pump multiplier bits, bit 0 worth one.
   function automatic logic [6:0] mult_sum(input logic [5:0] bits);
      logic [6:0] acc;
      acc = 7'h00;
      for (int k = 0; k < 6; k++) begin
         if (bits[k]) begin
            acc = acc + (7'h01 << k);
         end
      end
      mult_sum = acc;
   endfunction : mult_sum

   // Weighted divisor sum of the /24 and /3 pump bits.
   function automatic logic [4:0] div_sum(input logic div24, input logic div3);
      logic [4:0] acc;
      acc = 5'h00;
      if (div24) begin
         acc = acc + 5'h18;
      end
      if (div3) begin
         acc = acc + 5'h03;
      end
      div_sum = acc;
   endfunction : div_sum

   // ==========================================================
   // Storage: committed bank, staged bytes and the mask of staged lanes.
   logic [7:0] bank [NUM_REGS];
   logic [7:0] staged [NUM_REGS];
   logic [NUM_REGS-1:0] staged_mask;
   logic wr_hit;
   logic [IDX_W-1:0] wr_idx;
   logic [IDX_W-1:0] rd_idx;

   assign wr_hit = wr_valid_i && addr_in_bank(wr_req_i.addr);
   assign wr_idx = addr_index(wr_req_i.addr);
   assign rd_idx = addr_index(rd_addr_i);

   // Incoming bytes go to the staging lanes, and also straight to the bank in the STOP cycle, so a block write never shows half-applied
   // settings to the PLLs; writes outside the bank are dropped silently.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            staged[i] <= 8'h00;
         end
      end else if (wr_hit) begin
         staged[wr_idx] <= wr_req_i.data;
      end
   end

   // The mask marks lanes written since the last STOP and empties at STOP.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         staged_mask <= '0;
      end else if (stop_i) begin
         staged_mask <= '0;
      end else if (wr_hit) begin
         staged_mask[wr_idx] <= 1'b1;
      end
   end

   // At STOP every staged lane moves into the bank on the same edge. A byte arriving in the
   // STOP cycle itself is still taken into that block rather than lost.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            bank[i] <= RESET_IMAGE[i*8 +: 8];
         end
      end else if (stop_i) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            if (wr_hit && (wr_idx == i[IDX_W-1:0])) begin
               bank[i] <= wr_req_i.data;
            end else if (staged_mask[i]) begin
               bank[i] <= staged[i];
            end
         end
      end
   end

   assign stage_pending_o = |staged_mask;

   // ==========================================================
   // Read port: registered data one cycle after the request. Reads see the committed bank,
   // so bytes staged but not yet committed read back their old value.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_data_o <= 8'h00;
      end else if (rd_valid_i) begin
         if (addr_in_bank(rd_addr_i)) begin
            rd_data_o <= bank[rd_idx];
         end else begin
            rd_data_o <= 8'h00;
         end
      end
   end

   // Acknowledge pulse that marks rd_data_o as fresh.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_ack_o <= 1'b0;
      end else begin
         rd_ack_o <= rd_valid_i;
      end
   end

   // ==========================================================
   // Field fan-out, wired straight from the bank flip-flops.
   logic [7:0] b02;
   logic [7:0] b03;
   logic [7:0] b04;
   logic [7:0] b05;
   logic [7:0] b06;
   logic [7:0] b07;
   logic [7:0] b08;
   logic [7:0] b09;
   logic [7:0] b0a;
   logic [7:0] b0b;

   assign b02 = bank[0];
   assign b03 = bank[1];
   assign b04 = bank[2];
   assign b05 = bank[3];
   assign b06 = bank[4];
   assign b07 = bank[5];
   assign b08 = bank[6];
   assign b09 = bank[7];
   assign b0a = bank[8];
   assign b0b = bank[9];

   // Crystal trim, divider 3 source and divider 5 code.
   assign misc_cfg_o.crystal_load_trim = b02;
   assign misc_cfg_o.divider3_source_select = b06[POS_DIV3_SOURCE];
   assign misc_cfg_o.divider5_code = b07[POS_DIV5_MSB:0];

   // Third PLL reference path and dividers.
   assign third_pll_cfg_o.third_pll_ref_bypass_div1 = b03[POS_BYPASS_DIV1];
   assign third_pll_cfg_o.third_pll_ref_path_div2 = b03[POS_PATH_DIV2];
   assign third_pll_cfg_o.third_pll_ref_divider = b03[POS_REF_DIV_MSB:0];
   assign third_pll_cfg_o.third_pll_feedback_divider = {b05[POS_FB_HIGH_MSB:0], b04};

   // Third PLL loop filter; the 6k flag is passed raw and the analogue side applies it alone.
   assign third_pll_cfg_o.third_pll_filter_res = b05[POS_FILTER_MSB:POS_FILTER_LSB];
   assign third_pll_cfg_o.third_pll_filter_res_6k_only = b05[POS_FILTER_LOW_ONLY];

   // Third PLL charge pump and reference current.
   assign third_pll_cfg_o.third_pll_pump_mult = b06[POS_PLL3_MULT_MSB:POS_PLL3_MULT_LSB];
   assign third_pll_cfg_o.third_pll_pump_div24 = b06[POS_PLL3_DIV24];
   assign third_pll_cfg_o.third_pll_pump_div3 = b06[POS_PLL3_DIV3];
   assign third_pll_cfg_o.third_pll_ref_current_sel = b06[POS_PLL3_IREF];

   // First PLL control bits.
   assign first_pll_cfg_o.first_pll_ref_doubler = b07[POS_DOUBLER];
   assign first_pll_cfg_o.first_pll_ref_current_sel = b07[POS_PLL1_IREF];
   assign first_pll_cfg_o.first_pll_channel2_enable = b07[POS_CH2_EN];
   assign first_pll_cfg_o.first_pll_third_pole_enable = b07[POS_THIRD_POLE];

   // First PLL reference path and dividers.
   assign first_pll_cfg_o.first_pll_ref_bypass_div1 = b08[POS_BYPASS_DIV1];
   assign first_pll_cfg_o.first_pll_ref_path_div2 = b08[POS_PATH_DIV2];
   assign first_pll_cfg_o.first_pll_ref_divider = b08[POS_REF_DIV_MSB:0];
   assign first_pll_cfg_o.first_pll_feedback_divider = {b0a[POS_FB_HIGH_MSB:0], b09};

   // First PLL loop filter.
   assign first_pll_cfg_o.first_pll_filter_res = b0a[POS_FILTER_MSB:POS_FILTER_LSB];
   assign first_pll_cfg_o.first_pll_filter_res_1k_only = b0a[POS_FILTER_LOW_ONLY];

   // First PLL charge pump.
   assign first_pll_cfg_o.first_pll_pump_mult = b0b[POS_PLL1_MULT_MSB:POS_PLL1_MULT_LSB];
   assign first_pll_cfg_o.first_pll_pump_div24 = b0b[POS_PLL1_DIV24];
   assign first_pll_cfg_o.first_pll_pump_div3 = b0b[POS_PLL1_DIV3];

   // ==========================================================
   // Pump current ratio terms, so the bias generator needs no adder of its own. The
   // reference-current doubling is left to the analogue side, which owns the current source.
   assign third_pll_pump_num_o = mult_sum({2'b00, b06[POS_PLL3_MULT_MSB:POS_PLL3_MULT_LSB]});
   assign third_pll_pump_den_o = div_sum(b06[POS_PLL3_DIV24], b06[POS_PLL3_DIV3]);
   assign first_pll_pump_num_o = mult_sum(b0b[POS_PLL1_MULT_MSB:POS_PLL1_MULT_LSB]);
   assign first_pll_pump_den_o = div_sum(b0b[POS_PLL1_DIV24], b0b[POS_PLL1_DIV3]);

endmodule : pll_config_register_bank

// *** pll_config_register_bank_chk.sv ***
// Checker with the port assertions of the PLL configuration register bank.
module pll_config_register_bank_chk
   import pll_config_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic wr_valid_i,
   input wire byte_write_t wr_req_i,
   input wire logic stop_i,
   input wire logic rd_valid_i,
   input wire logic [7:0] rd_addr_i,
   input wire logic [7:0] rd_data_o,
   input wire logic rd_ack_o,
   input wire logic stage_pending_o,
   input wire third_pll_cfg_t third_pll_cfg_o,
   input wire first_pll_cfg_t first_pll_cfg_o,
   input wire misc_cfg_t misc_cfg_o,
   input wire logic [6:0] third_pll_pump_num_o,
   input wire logic [4:0] third_pll_pump_den_o,
   input wire logic [6:0] first_pll_pump_num_o,
   input wire logic [4:0] first_pll_pump_den_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // One clock domain, so clocking and reset are declared once.
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   // A write that lands on a mapped byte.
   wire wr_hit = wr_valid_i && wr_req_i.addr >= 8'h02 && wr_req_i.addr <= 8'h0b;

   // A read aimed below or above the bank, kept apart so the property fits on its label line.
   wire rd_unmapped = rd_valid_i && (rd_addr_i < 8'h02 || rd_addr_i > 8'h0b);

   AST_ACK_FOLLOWS: assert property (rd_valid_i |=> rd_ack_o)
      else $error("read acknowledge missing one cycle after request");
   AST_ACK_ONLY: assert property (!rd_valid_i |=> !rd_ack_o)
      else $error("read acknowledge without request");
   AST_UNMAPPED_ZERO: assert property (rd_unmapped |=> rd_data_o == 8'h00)
      else $error("unmapped read returned nonzero data");
   AST_TRIM_READ: assert property ((rd_valid_i && rd_addr_i == 8'h02 && !stop_i)
      |=> rd_data_o == $past(misc_cfg_o.crystal_load_trim))
      else $error("trim read differs from trim output");
   AST_FB_READ: assert property ((rd_valid_i && rd_addr_i == 8'h04 && !stop_i)
      |=> rd_data_o == $past(third_pll_cfg_o.third_pll_feedback_divider[7:0]))
      else $error("feedback low read differs from divider output");
   AST_HOLD_UNTIL_STOP: assert property (!stop_i |=> $stable(third_pll_cfg_o)
      && $stable(first_pll_cfg_o) && $stable(misc_cfg_o))
      else $error("configuration changed without a stop");
   AST_PENDING_SET: assert property ((wr_hit && !stop_i) |=> stage_pending_o)
      else $error("staged write not flagged pending");
   AST_PENDING_CLEAR: assert property (stop_i |=> !stage_pending_o)
      else $error("pending flag survived a stop");
   AST_PENDING_KEEP: assert property ((stage_pending_o && !stop_i) |=> stage_pending_o)
      else $error("pending flag dropped before stop");
   AST_PUMP_THIRD: assert property (third_pll_pump_num_o == {3'b000,
      third_pll_cfg_o.third_pll_pump_mult} && third_pll_pump_den_o ==
      (third_pll_cfg_o.third_pll_pump_div24 ? 5'h18 : 5'h00) +
      (third_pll_cfg_o.third_pll_pump_div3 ? 5'h03 : 5'h00))
      else $error("third pump ratio wrong");
   AST_PUMP_FIRST: assert property (first_pll_pump_num_o == {1'b0,
      first_pll_cfg_o.first_pll_pump_mult} && first_pll_pump_den_o ==
      (first_pll_cfg_o.first_pll_pump_div24 ? 5'h18 : 5'h00) +
      (first_pll_cfg_o.first_pll_pump_div3 ? 5'h03 : 5'h00))
      else $error("first pump ratio wrong");
endmodule : pll_config_register_bank_chk

bind pll_config_register_bank pll_config_register_bank_chk chk_u (.clk_sys_i, .rst_n_i,
   .wr_valid_i, .wr_req_i, .stop_i, .rd_valid_i, .rd_addr_i, .rd_data_o, .rd_ack_o,
   .stage_pending_o, .third_pll_cfg_o, .first_pll_cfg_o, .misc_cfg_o, .third_pll_pump_num_o,
   .third_pll_pump_den_o, .first_pll_pump_num_o, .first_pll_pump_den_o);

// *** pll_config_register_bank_tb.sv ***
// Self-checking testbench of the PLL configuration register bank.
module pll_config_register_bank_tb
   import pll_config_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Power-up bytes, 0Bh in the top lane down to 02h.
   localparam logic [79:0] DEFAULTS = {8'h06, 8'hb2, 8'h58, 8'h19, 8'h23,
      8'h6c, 8'h11, 8'he0, 8'h19, 8'h11};
   logic clk_sys_i, rst_n_i, wr_valid_i, stop_i, rd_valid_i, rd_ack_o, stage_pending_o;
   byte_write_t wr_req_i;
   logic [7:0] rd_addr_i, rd_data_o;
   third_pll_cfg_t third_pll_cfg_o;
   first_pll_cfg_t first_pll_cfg_o;
   misc_cfg_t misc_cfg_o;
   logic [6:0] third_pll_pump_num_o, first_pll_pump_num_o;
   logic [4:0] third_pll_pump_den_o, first_pll_pump_den_o;
   logic [7:0] cur [16];
   logic [7:0] stg [16];
   logic [15:0] stv;
   integer seed = 32'h8b67bb68;
   int fail_count = 0;
   int total_checks = 0;

   pll_config_register_bank dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .wr_valid_i(wr_valid_i), .wr_req_i(wr_req_i), .stop_i(stop_i), .rd_valid_i(rd_valid_i),
      .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .rd_ack_o(rd_ack_o),
      .stage_pending_o(stage_pending_o), .third_pll_cfg_o(third_pll_cfg_o),
      .first_pll_cfg_o(first_pll_cfg_o), .misc_cfg_o(misc_cfg_o),
      .third_pll_pump_num_o(third_pll_pump_num_o), .third_pll_pump_den_o(third_pll_pump_den_o),
      .first_pll_pump_num_o(first_pll_pump_num_o), .first_pll_pump_den_o(first_pll_pump_den_o));

   // 40 MHz clock.
   initial begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end

   // ==========================================================
   // Helpers: comparison, model reset, one driven cycle, reads.
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string nm);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic model_reset();
      for (int i = 0; i < 16; i++) cur[i] = 8'h00;
      for (int i = 0; i < 10; i++) cur[i+2] = DEFAULTS[i*8+:8];
      stv = '0;
   endtask : model_reset

   // The model moves at drive time; the design follows one edge later, and checks
   // are only made after an idle cycle, so the two stay in step.
   task automatic cyc(input logic wv, input logic [7:0] wa, input logic [7:0] wd,
                      input logic st, input logic rv, input logic [7:0] ra);
      @(posedge clk_sys_i);
      #1;
      wr_valid_i = wv;
      wr_req_i = {wa, wd};
      stop_i = st;
      rd_valid_i = rv;
      rd_addr_i = ra;
      if (wv && wa >= 8'h02 && wa <= 8'h0b) begin
         stg[wa[3:0]] = wd;
         stv[wa[3:0]] = 1'b1;
      end
      if (st) begin
         for (int i = 2; i < 12; i++) if (stv[i]) cur[i] = stg[i];
         stv = '0;
      end
   endtask : cyc

   task automatic idle();
      cyc(1'b0, 8'h00, 8'h00, 1'b0, 1'b0, 8'h00);
   endtask : idle

   task automatic rd(input logic [7:0] a);
      logic [7:0] e;
      e = (a >= 8'h02 && a <= 8'h0b) ? cur[a[3:0]] : 8'h00;
      cyc(1'b0, 8'h00, 8'h00, 1'b0, 1'b1, a);
      idle();
      chk(rd_ack_o, 1'b1, "rd_ack");
      chk(rd_data_o, e, "rd_data");
   endtask : rd

   task automatic chk_all();
      logic [30:0] exp3;
      logic [35:0] exp1;
      // Expected carriers are packed from the model bytes in field order.
      exp3 = {cur[3], cur[5][2:0], cur[4], cur[5][7:3], cur[6][6:0]};
      exp1 = {cur[7][7:4], cur[8], cur[10][2:0], cur[9], cur[10][7:3], cur[11]};
      chk(third_pll_cfg_o, exp3, "pll3");
      chk(first_pll_cfg_o, exp1, "pll1");
      chk(misc_cfg_o, {cur[2], cur[6][7], cur[7][3:0]}, "misc");
      chk(third_pll_pump_num_o, cur[6][6:3], "num3");
      chk(third_pll_pump_den_o, (cur[6][2] ? 24 : 0) + (cur[6][1] ? 3 : 0), "den3");
      chk(first_pll_pump_num_o, cur[11][7:2], "num1");
      chk(first_pll_pump_den_o, (cur[11][1] ? 24 : 0) + (cur[11][0] ? 3 : 0), "den1");
      chk(stage_pending_o, |stv, "pending");
   endtask : chk_all

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrap_up

   // Watchdog sized well beyond the few hundred cycles the tests need.
   initial begin
      #100000;
      fail_count++;
      wrap_up();
   end

   // ==========================================================
   // Main sequence.
   initial begin
      logic [7:0] a;
      rst_n_i = 1'b0;
      wr_valid_i = 1'b0;
      wr_req_i = '0;
      stop_i = 1'b0;
      rd_valid_i = 1'b0;
      rd_addr_i = 8'h00;
      model_reset();
      repeat (12) @(posedge clk_sys_i);
      #1 rst_n_i = 1'b1;
      idle();
      chk_all();
      chk(third_pll_cfg_o.third_pll_feedback_divider, 11'h1e0, "fb3_reset");
      chk(first_pll_cfg_o.first_pll_feedback_divider, 11'h258, "fb1_reset");
      for (int i = 0; i < 16; i++) rd(8'(i));
      $display("test reset_values done");
      // Split divider staged over two bytes, old value read back until stop.
      cyc(1'b1, 8'h04, 8'haa, 1'b0, 1'b0, 8'h00);
      cyc(1'b1, 8'h05, 8'h13, 1'b0, 1'b0, 8'h00);
      idle();
      chk_all();
      rd(8'h04);
      cyc(1'b0, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00);
      idle();
      chk_all();
      chk(third_pll_cfg_o.third_pll_feedback_divider, 11'h3aa, "fb3_commit");
      $display("test block_commit done");
      // Random writes, unmapped and rewritten addresses, stops joined to writes.
      repeat (60) begin
         a = 8'($unsigned($random(seed)) % 16);
         if ($random(seed) % 8 == 0) a = 8'hf2;
         cyc(1'b1, a, 8'($random(seed)), ($random(seed) % 4) == 0, 1'b0, 8'h00);
         idle();
         chk_all();
      end
      cyc(1'b0, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00);
      cyc(1'b0, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00);
      idle();
      chk_all();
      for (int i = 2; i < 12; i++) rd(8'(i));
      $display("test random_blocks done");
      // Reset in mid-run drops staged bytes and restores defaults.
      cyc(1'b1, 8'h07, 8'h5a, 1'b0, 1'b0, 8'h00);
      cyc(1'b1, 8'h0b, 8'hff, 1'b1, 1'b0, 8'h00);
      cyc(1'b1, 8'h02, 8'h7e, 1'b0, 1'b0, 8'h00);
      idle();
      chk_all();
      // Reset is dropped in the same drive slot as every other input change.
      rst_n_i = 1'b0;
      model_reset();
      repeat (2) @(posedge clk_sys_i);
      #1 rst_n_i = 1'b1;
      idle();
      chk_all();
      // A stop after reset must not apply the byte that was staged before it.
      cyc(1'b0, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00);
      idle();
      chk_all();
      $display("test midrun_reset done");
      wrap_up();
   end
endmodule : pll_config_register_bank_tb
